/* arb_defines.svh */
// Constants for the two-master AHB-Lite arbiter: bus widths and field positions.
// Assumes AHB-Lite signal widths as used on the shared sub-bus.
`ifndef ARB_DEFINES_SVH
`define ARB_DEFINES_SVH

`define ARB_ADDR_W          32
`define ARB_DATA_W          32
`define ARB_TRANS_W         2
`define ARB_SIZE_W          2
`define ARB_TRANS_ACTIVE_BIT 1
`define ARB_TRANS_IDLE      2'h0

`endif

/* arb_pkg.sv */
// Types shared by the arbiter, its held address stage and their interface.
// Assumes arb_defines.svh is on the include path.
package arb_pkg;
  `include "arb_defines.svh"

  typedef logic [`ARB_ADDR_W-1:0]  addr_t;
  typedef logic [`ARB_DATA_W-1:0]  data_t;
  typedef logic [`ARB_TRANS_W-1:0] trans_t;
  typedef logic [`ARB_SIZE_W-1:0]  size_t;

  typedef enum logic [1:0] {
    addr_route_direct_m0 = 2'b00,
    addr_route_held_m0   = 2'b01,
    addr_route_held_m1   = 2'b10
  } addr_route_e;

  typedef enum logic [1:0] {
    data_route_idle     = 2'b00,
    data_route_owner_m0 = 2'b01,
    data_route_owner_m1 = 2'b10
  } data_route_e;
endpackage

/* aphase_if.sv */
// Bundle of AHB-Lite address-phase signals passed between the arbiter and its hold stages.
// Assumes arb_pkg is compiled first.
`timescale 1ns/10ps
interface aphase_if;
  import arb_pkg::*;
  addr_t  haddr;
  trans_t htrans;
  size_t  hsize;
  logic   hwrite;
  modport drive  (output haddr, output htrans, output hsize, output hwrite);
  modport sample (input haddr, input htrans, input hsize, input hwrite);
endinterface

/* aphase_hold.sv */
// Held copy of one master's address phase with its valid flag.
// Assumes capture and discard are never raised together, and one clock with a sync reset.
`timescale 1ns/10ps
module aphase_hold (
  input  wire logic  mclk,
  input  wire logic  reset,
  input  wire logic  capture,
  input  wire logic  discard,
  aphase_if.sample   live,
  aphase_if.drive    held,
  output logic       valid
);
  import arb_pkg::*;

  addr_t  haddr_q;
  trans_t htrans_q;
  size_t  hsize_q;
  logic   hwrite_q;
  logic   valid_q;

  always_ff @(posedge mclk) begin
    if (reset) begin
      valid_q <= 1'h0;
    end else if (capture) begin
      valid_q <= 1'h1;
    end else if (discard) begin
      valid_q <= 1'h0;
    end
  end

  // The payload needs no reset; it is only looked at while valid is high.
  always_ff @(posedge mclk) begin
    if (capture) begin
      haddr_q  <= live.haddr;
      htrans_q <= live.htrans;
      hsize_q  <= live.hsize;
      hwrite_q <= live.hwrite;
    end
  end

  assign held.haddr  = haddr_q;
  assign held.htrans = htrans_q;
  assign held.hsize  = hsize_q;
  assign held.hwrite = hwrite_q;
  assign valid       = valid_q;
endmodule

/* two_master_ahb_lite_arbiter.sv */
// Arbiter letting two AHB-Lite masters (m0 core, m1 DMA) share one AHB-Lite slave bus.
// Assumes both masters and the slave run on mclk and the slave holds hreadyout_s high when idle.
//
// Functional notes
// - Track address and data phase per master.
// - Address route: direct m0, held m0, held m1.
// - Data route: idle, owner m0, owner m1.
// - Held-address flag for stalled m0.
// - Held flag m1: every accepted m1 address, stalled or not.
// - m0 request is select AND trans bit one.
// - m1 request is select AND trans bit one.
// - Direct route passes m0 address combinationally.
// - Held routes drive captured, not live, signals.
// - Direct m0 is the default address route.
// - Idle data route drives data signals zero.
// - Owner m0: m0 data, ready to m0.
// - Owner m1: m1 data, ready to m1.
// - Stalled master never sees slave ready.
// - Capture only when not waiting; else ready low.
// - Next route arbitrates live and held requests.
// - Next owner from slave ready and route.
// - Next-state logic makes capture and discard controls.
// - Unreachable state sets sticky error until reset.
// - m0 alone sees no added latency.
// - Simultaneous start after idle grants m0.
// - Back-to-back collision grants the other master.
`timescale 1ns/10ps
`include "arb_defines.svh"
module two_master_ahb_lite_arbiter (
  input  wire logic           mclk,
  input  wire logic           reset,
  input  wire logic           hsel_m0,
  input  wire arb_pkg::addr_t  haddr_m0,
  input  wire arb_pkg::trans_t htrans_m0,
  input  wire arb_pkg::size_t  hsize_m0,
  input  wire logic           hwrite_m0,
  input  wire arb_pkg::data_t  hwdata_m0,
  output arb_pkg::data_t      hrdata_m0,
  output logic                hready_m0,
  input  wire logic           hsel_m1,
  input  wire arb_pkg::addr_t  haddr_m1,
  input  wire arb_pkg::trans_t htrans_m1,
  input  wire arb_pkg::size_t  hsize_m1,
  input  wire logic           hwrite_m1,
  input  wire arb_pkg::data_t  hwdata_m1,
  output arb_pkg::data_t      hrdata_m1,
  output logic                hready_m1,
  output arb_pkg::addr_t      haddr_s,
  output arb_pkg::trans_t     htrans_s,
  output arb_pkg::size_t      hsize_s,
  output logic                hwrite_s,
  output arb_pkg::data_t      hwdata_s,
  input  wire arb_pkg::data_t  hrdata_s,
  input  wire logic           hreadyout_s,
  output logic                arb_error
);
  import arb_pkg::*;

  addr_route_e ap_q;
  addr_route_e ap_d;
  data_route_e dp_q;
  data_route_e dp_d;
  logic        last_m1_q;
  logic        last_m1_d;
  logic        err_q;
  logic        err_d;

  logic        bus_request_m0;
  logic        bus_request_m1;
  logic        held_addr_valid_m0;
  logic        held_addr_valid_m1;
  logic        capture_addr_m0;
  logic        capture_addr_m1;
  logic        discard_addr_m0;
  logic        discard_addr_m1;
  logic        held_next_m0;
  logic        held_next_m1;
  logic        direct_open;
  trans_t      direct_trans;
  logic        slave_take;
  logic        take_direct;
  logic        take_held_m0;
  logic        take_held_m1;
  logic        accept_m0;
  logic        accept_m1;
  logic        keep_route;
  logic        route_illegal;
  logic        data_illegal;
  logic        state_illegal;

  aphase_if live_m0 ();
  aphase_if live_m1 ();
  aphase_if held_m0 ();
  aphase_if held_m1 ();

  assign live_m0.haddr  = haddr_m0;
  assign live_m0.htrans = htrans_m0;
  assign live_m0.hsize  = hsize_m0;
  assign live_m0.hwrite = hwrite_m0;
  assign live_m1.haddr  = haddr_m1;
  assign live_m1.htrans = htrans_m1;
  assign live_m1.hsize  = hsize_m1;
  assign live_m1.hwrite = hwrite_m1;

  assign bus_request_m0 = hsel_m0 & htrans_m0[`ARB_TRANS_ACTIVE_BIT];
  assign bus_request_m1 = hsel_m1 & htrans_m1[`ARB_TRANS_ACTIVE_BIT];

  // A master is ready only while it owns the finishing data phase, or while the slave
  // is free and nothing of its own is held. The other master's completion never leaks.
  assign hready_m0 = ~held_addr_valid_m0 &
                     (((dp_q == data_route_owner_m0) & hreadyout_s) |
                      (dp_q == data_route_idle));
  assign hready_m1 = ~held_addr_valid_m1 &
                     (((dp_q == data_route_owner_m1) & hreadyout_s) |
                      (dp_q == data_route_idle));

  // Live m0 is masked while m1 owns the data phase, so the slave cannot take an address
  // that m0 still believes is stalled; this costs m0 a cycle only when m1 is active.
  assign direct_open  = (dp_q != data_route_owner_m1) & ~held_addr_valid_m0;
  assign direct_trans = (hsel_m0 & direct_open) ? htrans_m0 : `ARB_TRANS_IDLE;

  always_comb begin
    route_illegal = 1'h0;
    unique case (ap_q)
      addr_route_direct_m0: begin
        haddr_s  = haddr_m0;
        htrans_s = direct_trans;
        hsize_s  = hsize_m0;
        hwrite_s = hwrite_m0;
      end
      addr_route_held_m0: begin
        haddr_s  = held_m0.haddr;
        htrans_s = held_m0.htrans;
        hsize_s  = held_m0.hsize;
        hwrite_s = held_m0.hwrite;
      end
      addr_route_held_m1: begin
        haddr_s  = held_m1.haddr;
        htrans_s = held_m1.htrans;
        hsize_s  = held_m1.hsize;
        hwrite_s = held_m1.hwrite;
      end
      default: begin
        route_illegal = 1'h1;
        haddr_s  = haddr_m0;
        htrans_s = `ARB_TRANS_IDLE;
        hsize_s  = hsize_m0;
        hwrite_s = hwrite_m0;
      end
    endcase
  end

  always_comb begin
    data_illegal = 1'h0;
    hwdata_s     = '0;
    hrdata_m0    = '0;
    hrdata_m1    = '0;
    unique case (dp_q)
      data_route_idle: begin
        hwdata_s = '0;
      end
      data_route_owner_m0: begin
        hwdata_s  = hwdata_m0;
        hrdata_m0 = hrdata_s;
      end
      data_route_owner_m1: begin
        hwdata_s  = hwdata_m1;
        hrdata_m1 = hrdata_s;
      end
      default: begin
        data_illegal = 1'h1;
      end
    endcase
  end

  // The slave samples an address phase when its own ready is high.
  assign slave_take   = htrans_s[`ARB_TRANS_ACTIVE_BIT] & hreadyout_s;
  assign take_direct  = slave_take & (ap_q == addr_route_direct_m0);
  assign take_held_m0 = slave_take & (ap_q == addr_route_held_m0);
  assign take_held_m1 = slave_take & (ap_q == addr_route_held_m1);

  // A master believes its address accepted whenever it requests with its ready high.
  assign accept_m0 = bus_request_m0 & hready_m0;
  assign accept_m1 = bus_request_m1 & hready_m1;

  assign capture_addr_m0 = accept_m0 & ~take_direct;
  assign capture_addr_m1 = accept_m1;
  assign discard_addr_m0 = take_held_m0;
  assign discard_addr_m1 = take_held_m1;

  assign held_next_m0 = capture_addr_m0 | (held_addr_valid_m0 & ~discard_addr_m0);
  assign held_next_m1 = capture_addr_m1 | (held_addr_valid_m1 & ~discard_addr_m1);

  aphase_hold u_hold_m0 (
    .mclk    (mclk),
    .reset   (reset),
    .capture (capture_addr_m0),
    .discard (discard_addr_m0),
    .live    (live_m0),
    .held    (held_m0),
    .valid   (held_addr_valid_m0)
  );

  aphase_hold u_hold_m1 (
    .mclk    (mclk),
    .reset   (reset),
    .capture (capture_addr_m1),
    .discard (discard_addr_m1),
    .live    (live_m1),
    .held    (held_m1),
    .valid   (held_addr_valid_m1)
  );

  // A held address on the slave must stay put until the slave takes it.
  assign keep_route = (ap_q != addr_route_direct_m0) & ~slave_take;
  assign last_m1_d  = slave_take ? (ap_q == addr_route_held_m1) : last_m1_q;

  // Live m0 wins a fresh collision by riding the direct route while m1 is captured.
  assign ap_d = keep_route                  ? ap_q :
                (held_next_m0 & held_next_m1) ? (last_m1_d ? addr_route_held_m0
                                                           : addr_route_held_m1) :
                held_next_m0                ? addr_route_held_m0 :
                held_next_m1                ? addr_route_held_m1 :
                                              addr_route_direct_m0;

  assign dp_d = ~hreadyout_s ? dp_q :
                ~slave_take  ? data_route_idle :
                (ap_q == addr_route_held_m1) ? data_route_owner_m1
                                             : data_route_owner_m0;

  assign state_illegal = route_illegal | data_illegal |
                         ((ap_q == addr_route_held_m0) & ~held_addr_valid_m0) |
                         ((ap_q == addr_route_held_m1) & ~held_addr_valid_m1) |
                         (held_addr_valid_m0 & (dp_q == data_route_owner_m0)) |
                         (held_addr_valid_m1 & (dp_q == data_route_owner_m1));
  assign err_d = err_q | state_illegal;

  always_ff @(posedge mclk) begin
    if (reset) begin
      ap_q      <= addr_route_direct_m0;
      dp_q      <= data_route_idle;
      last_m1_q <= 1'h1;
      err_q     <= 1'h0;
    end else begin
      ap_q      <= ap_d;
      dp_q      <= dp_d;
      last_m1_q <= last_m1_d;
      err_q     <= err_d;
    end
  end

  assign arb_error = err_q;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  property p_direct_pass;
    (ap_q == addr_route_direct_m0) |-> (haddr_s == haddr_m0) && (hsize_s == hsize_m0);
  endproperty
  a_direct_pass: assert property (p_direct_pass)
    else $error("direct route does not pass m0 address");

  property p_held_payload;
    capture_addr_m1 |=> (held_m1.haddr == $past(haddr_m1)) && held_addr_valid_m1;
  endproperty
  a_held_payload: assert property (p_held_payload)
    else $error("m1 address not captured");

  property p_idle_zero;
    (dp_q == data_route_idle) |-> (hwdata_s == '0) && (hrdata_m0 == '0) && (hrdata_m1 == '0);
  endproperty
  a_idle_zero: assert property (p_idle_zero)
    else $error("idle data route not zero");

  property p_owner_m0;
    (dp_q == data_route_owner_m0) |->
      (hready_m0 == hreadyout_s) && !hready_m1 && (hwdata_s == hwdata_m0);
  endproperty
  a_owner_m0: assert property (p_owner_m0)
    else $error("m0 data phase misrouted");

  property p_owner_m1;
    (dp_q == data_route_owner_m1) |->
      (hready_m1 == hreadyout_s) && !hready_m0 && (hwdata_s == hwdata_m1);
  endproperty
  a_owner_m1: assert property (p_owner_m1)
    else $error("m1 data phase misrouted");

  property p_held_stalls;
    held_addr_valid_m0 |-> !hready_m0 && !take_direct;
  endproperty
  a_held_stalls: assert property (p_held_stalls)
    else $error("held m0 sees ready");

  property p_m0_no_latency;
    (ap_q == addr_route_direct_m0) && (dp_q == data_route_idle) && bus_request_m0 &&
      !held_addr_valid_m0 && hreadyout_s |=> (dp_q == data_route_owner_m0);
  endproperty
  a_m0_no_latency: assert property (p_m0_no_latency)
    else $error("m0 delayed on free bus");

  property p_fresh_collision;
    (ap_q == addr_route_direct_m0) && (dp_q == data_route_idle) && bus_request_m0 &&
      !held_addr_valid_m0 && hreadyout_s && accept_m1 |-> take_direct && capture_addr_m1;
  endproperty
  a_fresh_collision: assert property (p_fresh_collision)
    else $error("fresh collision not granted to m0");

  property p_m1_to_slave;
    take_held_m1 |=> (dp_q == data_route_owner_m1) && !held_addr_valid_m1;
  endproperty
  a_m1_to_slave: assert property (p_m1_to_slave)
    else $error("m1 data phase not started");

  property p_alternate;
    slave_take && (ap_q == addr_route_held_m1) && held_addr_valid_m0 |=>
      (ap_q == addr_route_held_m0);
  endproperty
  a_alternate: assert property (p_alternate)
    else $error("back-to-back grant not alternated");

  property p_error_sticky;
    arb_error |=> arb_error [*4];
  endproperty
  a_error_sticky: assert property (p_error_sticky)
    else $error("error flag dropped");

  property p_reset_state;
    @(posedge mclk) disable iff (1'b0)
      reset |=> (ap_q == addr_route_direct_m0) && (dp_q == data_route_idle) &&
                !held_addr_valid_m0 && !held_addr_valid_m1 && !arb_error;
  endproperty
  a_reset_state: assert property (p_reset_state)
    else $error("reset state wrong");

  c_both_held: cover property (held_addr_valid_m0 && held_addr_valid_m1);
  c_m1_transfer: cover property (take_held_m1 ##1 hready_m1);
  c_m0_held_route: cover property (ap_q == addr_route_held_m0 ##1 dp_q == data_route_owner_m0);
  c_collision: cover property (accept_m0 && accept_m1 && dp_q == data_route_idle);
endmodule

/* slave_mem_model.sv */
// Behavioural AHB-Lite slave that stands on the shared sub-bus side of the arbiter.
// Assumes one clock, a synchronous active-high reset and word addresses below 64 bytes.
`timescale 1ns/10ps
module slave_mem_model (
  input  wire logic            mclk,
  input  wire logic            reset,
  input  wire arb_pkg::addr_t  haddr_s,
  input  wire arb_pkg::trans_t htrans_s,
  input  wire arb_pkg::size_t  hsize_s,
  input  wire logic            hwrite_s,
  input  wire arb_pkg::data_t  hwdata_s,
  input  wire logic [1:0]      wait_n,
  output arb_pkg::data_t       hrdata_s,
  output logic                 hreadyout_s
);
  import arb_pkg::*;
  data_t      mem [16];
  data_t      junk_q = 32'h5A5A_A5A5;
  logic       busy_q;
  logic       wr_q;
  logic [3:0] idx_q;
  logic [1:0] cnt_q;
  addr_t      taken [$];
  size_t      sizes [$];
  // Ready stays high while idle, which the arbiter relies on to let a master start.
  assign hreadyout_s = !busy_q || cnt_q == 2'h0;
  // Outside a valid read the data toggles, so a stale value can never pass for a good one.
  assign hrdata_s = (busy_q && !wr_q && hreadyout_s) ? mem[idx_q] : junk_q;
  always @(posedge mclk) begin
    junk_q <= ~junk_q;
    if (reset) begin
      busy_q <= 1'b0;
      cnt_q  <= 2'h0;
    end else begin
      if (busy_q && hreadyout_s && wr_q) begin
        mem[idx_q] <= hwdata_s;
      end
      if (hreadyout_s) begin
        busy_q <= htrans_s[1];
        wr_q   <= hwrite_s;
        idx_q  <= haddr_s[5:2];
        cnt_q  <= wait_n;
        if (htrans_s[1]) begin
          taken.push_back(haddr_s);
          sizes.push_back(hsize_s);
        end
      end else begin
        cnt_q <= cnt_q - 2'h1;
      end
    end
  end
endmodule

/* two_master_ahb_lite_arbiter_tb_top.sv */
// Self-checking bench: two master drivers and a slave model around the arbiter.
// Assumes arb_pkg and the design files are compiled first; inputs change at falling edges.
`timescale 1ns/10ps
module two_master_ahb_lite_arbiter_tb_top;
  import arb_pkg::*;
  logic       mclk;
  logic       reset;
  logic       sel [2];
  addr_t      addr [2];
  trans_t     trans [2];
  size_t      size [2];
  logic       wrt [2];
  data_t      wdat [2];
  data_t      rdat [2];
  logic       rdy [2];
  addr_t      haddr_s;
  trans_t     htrans_s;
  size_t      hsize_s;
  logic       hwrite_s;
  data_t      hwdata_s;
  data_t      hrdata_s;
  logic       hreadyout_s;
  logic       arb_error;
  logic [1:0] wait_n;
  int         errors;
  int         checks_done;

  two_master_ahb_lite_arbiter dut (
    .mclk(mclk), .reset(reset),
    .hsel_m0(sel[0]), .haddr_m0(addr[0]), .htrans_m0(trans[0]), .hsize_m0(size[0]),
    .hwrite_m0(wrt[0]), .hwdata_m0(wdat[0]), .hrdata_m0(rdat[0]), .hready_m0(rdy[0]),
    .hsel_m1(sel[1]), .haddr_m1(addr[1]), .htrans_m1(trans[1]), .hsize_m1(size[1]),
    .hwrite_m1(wrt[1]), .hwdata_m1(wdat[1]), .hrdata_m1(rdat[1]), .hready_m1(rdy[1]),
    .haddr_s(haddr_s), .htrans_s(htrans_s), .hsize_s(hsize_s), .hwrite_s(hwrite_s),
    .hwdata_s(hwdata_s), .hrdata_s(hrdata_s), .hreadyout_s(hreadyout_s),
    .arb_error(arb_error)
  );

  slave_mem_model u_slave (
    .mclk(mclk), .reset(reset), .haddr_s(haddr_s), .htrans_s(htrans_s), .hsize_s(hsize_s),
    .hwrite_s(hwrite_s), .hwdata_s(hwdata_s), .wait_n(wait_n),
    .hrdata_s(hrdata_s), .hreadyout_s(hreadyout_s)
  );

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic test_done;
    if (errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Samples well after the falling-edge drive, then lets the rising edge take it.
  task automatic wait_rdy(input int m, inout int n, output data_t rd);
    logic r;
    r = 1'b0;
    while (!r && n < 40) begin
      #3;
      r = rdy[m];
      rd = rdat[m];
      @(posedge mclk);
      n++;
    end
    if (!r) chk("ready wait", 1, 0);
  endtask

  // One single transfer; the address is held until taken, then shows its inverse.
  task automatic xfer(input int m, input addr_t a, input logic w, input data_t wd,
                      output data_t rd, output int n);
    n = 0;
    @(negedge mclk);
    sel[m] = 1'b1;
    addr[m] = a;
    trans[m] = 2'h2;
    wrt[m] = w;
    size[m] = a[3:2];
    wait_rdy(m, n, rd);
    @(negedge mclk);
    sel[m] = 1'b0;
    trans[m] = 2'h0;
    addr[m] = ~a;
    wdat[m] = wd;
    wait_rdy(m, n, rd);
  endtask

  task automatic t_idle;
    @(negedge mclk);
    #3;
    chk("arb_error", 0, arb_error);
    chk("hready_m0", 1, rdy[0]);
    chk("hready_m1", 1, rdy[1]);
    chk("htrans_s", 0, htrans_s);
    chk("hwdata_s", 0, hwdata_s);
    chk("hrdata_m0", 0, rdat[0]);
    chk("hrdata_m1", 0, rdat[1]);
  endtask

  task automatic t_solo(input int m);
    data_t rd;
    int    n;
    addr_t a;
    for (int w = 0; w < 3; w++) begin
      @(negedge mclk);
      wait_n = w[1:0];
      a = addr_t'(16 * m + 4 * w);
      u_slave.taken.delete();
      u_slave.sizes.delete();
      xfer(m, a, 1'b1, 32'hA500_0000 + a, rd, n);
      chk("write latency", 2 + w + m, n);
      xfer(m, a, 1'b0, 32'h0, rd, n);
      chk("read latency", 2 + w + m, n);
      chk("slave write size", w, u_slave.sizes[0]);
      chk("slave read size", w, u_slave.sizes[1]);
      chk("read data", 32'hA500_0000 + a, rd);
      chk("slave write addr", a, u_slave.taken[0]);
      chk("slave read addr", a, u_slave.taken[1]);
    end
  endtask

  // Slow m1 write owns the slave while m0 starts a read.
  task automatic t_stall;
    data_t rd0;
    data_t rd1;
    int    n0;
    int    n1;
    @(negedge mclk);
    wait_n = 2'h3;
    fork
      xfer(1, 32'h30, 1'b1, 32'hC3C3_0030, rd1, n1);
      begin
        @(negedge mclk);
        xfer(0, 32'h4, 1'b0, 32'h0, rd0, n0);
      end
    join
    chk("stalled m0 latency", 1, n0 >= 4);
    chk("stalled m0 data", 32'hA500_0004, rd0);
    xfer(0, 32'h30, 1'b0, 32'h0, rd0, n0);
    chk("m1 write landed", 32'hC3C3_0030, rd0);
  endtask

  // Both masters start together, then each goes straight on to a second transfer.
  task automatic t_collide;
    data_t rd [4];
    int    n [2];
    addr_t exp [4];
    exp = '{32'h0, 32'h10, 32'h8, 32'h18};
    @(negedge mclk);
    wait_n = 2'h0;
    u_slave.taken.delete();
    fork
      begin
        xfer(0, exp[0], 1'b0, 32'h0, rd[0], n[0]);
        xfer(0, exp[2], 1'b0, 32'h0, rd[2], n[0]);
      end
      begin
        xfer(1, exp[1], 1'b0, 32'h0, rd[1], n[1]);
        xfer(1, exp[3], 1'b0, 32'h0, rd[3], n[1]);
      end
    join
    for (int i = 0; i < 4; i++) begin
      chk("grant order", exp[i], u_slave.taken[i]);
      chk("collision data", 32'hA500_0000 + exp[i], rd[i]);
    end
  endtask

  initial begin
    errors = 0;
    checks_done = 0;
    reset = 1'b1;
    wait_n = 2'h0;
    for (int i = 0; i < 2; i++) begin
      sel[i] = 1'b0;
      addr[i] = 32'h0;
      trans[i] = 2'h0;
      size[i] = 2'h0;
      wrt[i] = 1'b0;
      wdat[i] = 32'h0;
    end
    repeat (10) @(negedge mclk);
    reset = 1'b0;
    t_idle();
    t_solo(0);
    t_solo(1);
    t_stall();
    t_collide();
    chk("arb_error", 0, arb_error);
    @(negedge mclk);
    reset = 1'b1;
    repeat (2) @(negedge mclk);
    reset = 1'b0;
    t_idle();
    test_done();
  end

  // The whole run needs about a hundred cycles; this is far beyond that.
  initial begin
    #100000;
    errors++;
    $display("[ERR] watchdog expected finish seen timeout");
    test_done();
  end
endmodule
